// ### pkg/fsk_cfg_pkg.sv
// constants, types and helpers shared by both ends of the modem configuration link
package fsk_cfg_pkg;

  // crystal is the system clock
  localparam int XTAL_HZ             = 10_000_000;
  localparam int MIN_SYM_RATE        = 2400;
  localparam int MAX_SYM_RATE        = 9600;
  localparam int SETTLE_SYMBOLS      = 20;
  localparam int NARROW_WAIT_SYMBOLS = 200;

  // register selection on the link
  localparam logic SEL_CONTROL = 1'b0;
  localparam logic SEL_MODE    = 1'b1;

  // modem_control fields
  localparam int DIV_HI = 7;
  localparam int DIV_LO = 6;
  localparam int TOL_HI = 5;
  localparam int TOL_LO = 4;
  localparam int LEV_HI = 3;
  localparam int LEV_LO = 2;
  localparam int BW_HI  = 1;
  localparam int BW_LO  = 0;

  // operating_mode fields
  localparam int IRQ_EN_BIT = 7;
  localparam int INV_BIT    = 6;
  localparam int TX_BIT     = 5;
  localparam int EYE_BIT    = 4;
  localparam int POWER_SAVE_BIT  = 3;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hF8;

  localparam logic [7:0] CONTROL_RST      = 8'h00;
  localparam logic [7:0] MODE_RST         = 8'h00;
  // divider 2048, four mismatches, level track, medium loop
  localparam logic [7:0] HOST_CONTROL_RST = 8'hA6;
  localparam logic [7:0] HOST_MODE_RST    = 8'h00;

  // host command port map
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_MODE    = 2'h1;
  localparam logic [1:0] ADDR_STATUS  = 2'h2;
  localparam int ST_SETTLING   = 0;
  localparam int ST_RATE_ERR   = 1;
  localparam int ST_NARROW_ERR = 2;

  localparam logic [12:0] DIV_BASE     = 13'h0200;
  localparam logic [7:0]  MISMATCH_MAX = 8'hFF;

  typedef enum logic [1:0] {
    LEV_HOLD  = 2'b00,
    LEV_TRACK = 2'b01,
    LEV_LOSSY = 2'b10,
    LEV_SLOW  = 2'b11
  } level_mode_t;

  typedef enum logic [1:0] {
    BW_HOLD   = 2'b00,
    BW_NARROW = 2'b01,
    BW_MEDIUM = 2'b10,
    BW_WIDE   = 2'b11
  } loop_bw_t;

  function automatic logic [12:0] div_ratio(input logic [1:0] code);
    div_ratio = DIV_BASE << code;
  endfunction : div_ratio

  function automatic logic rate_in_range(input logic [1:0] code);
    int rate;
    rate = XTAL_HZ / int'(div_ratio(code));
    rate_in_range = (rate >= MIN_SYM_RATE) && (rate <= MAX_SYM_RATE);
  endfunction : rate_in_range

  // symbol codes 00=-3 01=-1 10=+1 11=+3, distance in level steps
  function automatic logic [1:0] level_distance(input logic [1:0] a, input logic [1:0] b);
    level_distance = (a > b) ? 2'(a - b) : 2'(b - a);
  endfunction : level_distance

endpackage : fsk_cfg_pkg

// ### pkg/fsk_cfg_if.sv
// register write link between host controller and modem configuration bank
`timescale 1ns/1ns
interface fsk_cfg_if;
  logic       wr_stb;
  logic       reg_sel;
  logic [7:0] wr_data;

  modport dev  (input  wr_stb, input  reg_sel, input  wr_data);
  modport host (output wr_stb, output reg_sel, output wr_data);
endinterface : fsk_cfg_if

// ### design/fsk_cfg_device.sv
// modem-side configuration registers and the logic they steer
`timescale 1ns/1ns
module fsk_cfg_device
  import fsk_cfg_pkg::*;
(
  // clock, reset, enable
  input  wire logic       CLOCK,
  input  wire logic       RSTN,
  input  wire logic       CE,
  // register link
  fsk_cfg_if.dev          LINK,
  // status and sequencer inputs
  input  wire logic       STATUS_IRQ,
  input  wire logic       LEVEL_ACQ,
  input  wire logic       CLOCK_ACQ,
  // frame sync comparison
  input  wire logic       SYNC_START,
  input  wire logic       SYM_VALID,
  input  wire logic [1:0] RX_SYM,
  input  wire logic [1:0] EXP_SYM,
  input  wire logic       SYNC_LAST,
  // timing and modes
  output logic            SYMBOL_TICK,
  output logic            TX_MODE,
  output logic            INVERT_TX,
  output logic            INVERT_RX,
  output logic [1:0]      LEVEL_MODE,
  output logic            CAP_FLOAT,
  output logic [1:0]      LOOP_BW,
  output logic            LOOP_OPEN,
  output logic            EYE_ROUTE,
  output logic            POWER_DOWN,
  // events to task logic
  output logic            TASK_CANCEL,
  output logic            BUFFER_FREE_FLAG_SET,
  output logic            SYNC_FOUND,
  // open-drain interrupt pin
  output logic            IRQ_N_OUT,
  output logic            IRQ_N_OE
);

  typedef enum logic {
    SRCH_IDLE = 1'b0,
    SRCH_RUN  = 1'b1
  } search_state_t;

  logic [7:0]    control_r;
  logic [7:0]    mode_r;
  logic [12:0]   div_cnt_r;
  logic [12:0]   div_cnt_nxt;
  logic [7:0]    mism_r;
  logic [7:0]    mism_nxt;
  logic [3:0]    limit;
  search_state_t srch_r;
  logic          acq_found_r;
  logic          rx_mode;
  logic          tx_new;
  logic          ps_new;
  logic          mode_wr;
  logic          ctrl_wr;
  level_mode_t   lev_eff;
  loop_bw_t      bw_eff;

  assign ctrl_wr = LINK.wr_stb && (LINK.reg_sel == SEL_CONTROL);
  assign mode_wr = LINK.wr_stb && (LINK.reg_sel == SEL_MODE);
  assign tx_new  = LINK.wr_data[TX_BIT];
  assign ps_new  = LINK.wr_data[POWER_SAVE_BIT];
  assign rx_mode = !mode_r[TX_BIT];

  // write only: no read path exists, values persist until rewritten
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      control_r <= CONTROL_RST;
    end
    else if (CE && ctrl_wr)
    begin
      control_r <= LINK.wr_data;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      mode_r <= MODE_RST;
    end
    else if (CE && mode_wr)
    begin
      mode_r <= LINK.wr_data;
    end
  end

  // mode change events, one cycle each
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      TASK_CANCEL <= 1'b0;
      BUFFER_FREE_FLAG_SET   <= 1'b0;
    end
    else if (CE)
    begin
      TASK_CANCEL <= mode_wr && (tx_new != mode_r[TX_BIT]);
      // no interrupt request goes with this set
      BUFFER_FREE_FLAG_SET   <= mode_wr && ((tx_new != mode_r[TX_BIT]) ||
                                 (ps_new != mode_r[POWER_SAVE_BIT]));
    end
  end

  // symbol rate divider from the crystal clock
  always_comb
  begin
    if (div_cnt_r >= 13'(div_ratio(control_r[DIV_HI:DIV_LO]) - 13'h0001))
    begin
      div_cnt_nxt = 13'h0000;
    end
    else
    begin
      div_cnt_nxt = div_cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      div_cnt_r   <= 13'h0000;
      SYMBOL_TICK <= 1'b0;
    end
    else if (CE)
    begin
      div_cnt_r   <= div_cnt_nxt;
      SYMBOL_TICK <= (div_cnt_nxt == 13'h0000);
    end
  end

  // frame sync search: accumulate level distances, saturating
  always_comb
  begin
    mism_nxt = mism_r;
    if (SYM_VALID)
    begin
      if (mism_r > 8'(MISMATCH_MAX - 8'h03))
      begin
        mism_nxt = MISMATCH_MAX;
      end
      else
      begin
        mism_nxt = mism_r + 8'(level_distance(RX_SYM, EXP_SYM));
      end
    end
  end

  // tolerance code times two, widened to the limit's four bits
  assign limit = {1'b0, control_r[TOL_HI:TOL_LO], 1'b0};

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      srch_r     <= SRCH_IDLE;
      mism_r     <= 8'h00;
      SYNC_FOUND <= 1'b0;
    end
    else if (CE)
    begin
      SYNC_FOUND <= 1'b0;
      case (srch_r)
        SRCH_IDLE:
        begin
          // tolerance has no meaning while transmitting
          if (SYNC_START && rx_mode)
          begin
            srch_r <= SRCH_RUN;
            mism_r <= 8'h00;
          end
        end
        SRCH_RUN:
        begin
          if (!rx_mode)
          begin
            srch_r <= SRCH_IDLE;
          end
          else if (SYM_VALID && SYNC_LAST)
          begin
            srch_r     <= SRCH_IDLE;
            SYNC_FOUND <= (mism_nxt <= 8'(limit));
          end
          else
          begin
            mism_r <= mism_nxt;
          end
        end
        default:
        begin
          srch_r <= SRCH_IDLE;
        end
      endcase
    end
  end

  // remembers that sync was seen in the current level acquisition
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      acq_found_r <= 1'b0;
    end
    else if (CE)
    begin
      if (!LEVEL_ACQ)
      begin
        acq_found_r <= 1'b0;
      end
      else if (SYNC_FOUND)
      begin
        acq_found_r <= 1'b1;
      end
    end
  end

  always_comb
  begin
    if (LEVEL_ACQ && !acq_found_r)
    begin
      lev_eff = LEV_SLOW;
    end
    else
    begin
      lev_eff = level_mode_t'(control_r[LEV_HI:LEV_LO]);
    end
    if (CLOCK_ACQ)
    begin
      bw_eff = BW_WIDE;
    end
    else
    begin
      bw_eff = loop_bw_t'(control_r[BW_HI:BW_LO]);
    end
  end

  // receive path settings, parked when transmitting
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      LEVEL_MODE <= LEV_HOLD;
      CAP_FLOAT  <= 1'b0;
      LOOP_BW    <= BW_HOLD;
      LOOP_OPEN  <= 1'b0;
    end
    else if (CE)
    begin
      LEVEL_MODE <= rx_mode ? lev_eff : LEV_HOLD;
      CAP_FLOAT  <= rx_mode && (lev_eff == LEV_HOLD);
      LOOP_BW    <= rx_mode ? bw_eff : BW_HOLD;
      // open loop runs free on crystal and divider only
      LOOP_OPEN  <= rx_mode && (bw_eff == BW_HOLD);
    end
  end

  // mode outputs
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      TX_MODE    <= 1'b0;
      INVERT_TX  <= 1'b0;
      INVERT_RX  <= 1'b0;
      EYE_ROUTE  <= 1'b0;
      POWER_DOWN <= 1'b0;
    end
    else if (CE)
    begin
      TX_MODE    <= mode_r[TX_BIT];
      // default sense: +3 above bias on tx, below bias on rx
      INVERT_TX  <= mode_r[INV_BIT];
      INVERT_RX  <= !mode_r[INV_BIT];
      // tx buffer is off in powersave, so no eye either
      EYE_ROUTE  <= mode_r[EYE_BIT] && rx_mode && !mode_r[POWER_SAVE_BIT];
      POWER_DOWN <= mode_r[POWER_SAVE_BIT];
    end
  end

  // pin is pulled low only, never driven high
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      IRQ_N_OUT <= 1'b0;
      IRQ_N_OE  <= 1'b0;
    end
    else if (CE)
    begin
      IRQ_N_OUT <= 1'b0;
      IRQ_N_OE  <= mode_r[IRQ_EN_BIT] && STATUS_IRQ;
    end
  end

endmodule : fsk_cfg_device

// ### design/fsk_cfg_host.sv
// host-side controller that programs the modem configuration registers
`timescale 1ns/1ns
module fsk_cfg_host
  import fsk_cfg_pkg::*;
#(
  parameter int SETTLE_SYM = SETTLE_SYMBOLS,
  parameter int NARROW_SYM = NARROW_WAIT_SYMBOLS
)
(
  // clock, reset, enable
  input  wire logic       CLOCK,
  input  wire logic       RSTN,
  input  wire logic       CE,
  // software command port
  input  wire logic [1:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic [7:0]      RDATA,
  // register link
  fsk_cfg_if.host         LINK
);

  logic [7:0]  ctrl_r;
  logic [7:0]  mode_r;
  logic [12:0] cyc_r;
  logic        sym_tick;
  logic [7:0]  settle_r;
  logic [7:0]  medium_r;
  logic        rate_err_r;
  logic        narrow_err_r;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        bad_rate;
  logic        bad_narrow;
  logic        ok_ctrl;
  logic        wr_stb_r;
  logic        reg_sel_r;
  logic [7:0]  wr_data_r;

  assign wr_ctrl    = WR && (ADDR == ADDR_CONTROL);
  assign wr_mode    = WR && (ADDR == ADDR_MODE);
  assign bad_rate   = !rate_in_range(WDATA[DIV_HI:DIV_LO]);
  assign bad_narrow = (WDATA[BW_HI:BW_LO] == BW_NARROW) &&
                      (ctrl_r[BW_HI:BW_LO] != BW_NARROW) &&
                      (medium_r < 8'(NARROW_SYM));
  assign ok_ctrl    = wr_ctrl && !bad_rate && !bad_narrow;
  assign sym_tick   = (cyc_r >= 13'(div_ratio(ctrl_r[DIV_HI:DIV_LO]) - 13'h0001));

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      ctrl_r <= HOST_CONTROL_RST;
      mode_r <= HOST_MODE_RST;
    end
    else if (CE)
    begin
      if (ok_ctrl)
      begin
        ctrl_r <= WDATA;
      end
      if (wr_mode)
      begin
        mode_r <= WDATA & MODE_WRITE_MASK;
      end
    end
  end

  // one write on the link per accepted command write
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      wr_stb_r  <= 1'b0;
      reg_sel_r <= SEL_CONTROL;
      wr_data_r <= 8'h00;
    end
    else if (CE)
    begin
      wr_stb_r <= ok_ctrl || wr_mode;
      if (ok_ctrl)
      begin
        reg_sel_r <= SEL_CONTROL;
        wr_data_r <= WDATA;
      end
      else if (wr_mode)
      begin
        reg_sel_r <= SEL_MODE;
        wr_data_r <= WDATA & MODE_WRITE_MASK;
      end
    end
  end

  assign LINK.wr_stb  = wr_stb_r;
  assign LINK.reg_sel = reg_sel_r;
  assign LINK.wr_data = wr_data_r;

  // local copy of the symbol time, crystal equals CLOCK
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      cyc_r <= 13'h0000;
    end
    else if (CE)
    begin
      cyc_r <= sym_tick ? 13'h0000 : cyc_r + 13'h0001;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      settle_r <= 8'h00;
    end
    else if (CE)
    begin
      if (wr_mode && mode_r[POWER_SAVE_BIT] && !WDATA[POWER_SAVE_BIT])
      begin
        settle_r <= 8'(SETTLE_SYM);
      end
      else if (sym_tick && (settle_r != 8'h00))
      begin
        settle_r <= settle_r - 8'h01;
      end
    end
  end

  // symbols spent at medium bandwidth, saturating
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      medium_r <= 8'h00;
    end
    else if (CE)
    begin
      if (ctrl_r[BW_HI:BW_LO] != BW_MEDIUM)
      begin
        medium_r <= 8'h00;
      end
      else if (sym_tick && (medium_r < 8'(NARROW_SYM)))
      begin
        medium_r <= medium_r + 8'h01;
      end
    end
  end

  // sticky refusal flags, cleared by a status read; a new refusal wins
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      rate_err_r   <= 1'b0;
      narrow_err_r <= 1'b0;
    end
    else if (CE)
    begin
      rate_err_r   <= (wr_ctrl && bad_rate) ||
                      (rate_err_r && !(RD && (ADDR == ADDR_STATUS)));
      narrow_err_r <= (wr_ctrl && !bad_rate && bad_narrow) ||
                      (narrow_err_r && !(RD && (ADDR == ADDR_STATUS)));
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      RDATA <= 8'h00;
    end
    else if (CE)
    begin
      RDATA <= 8'h00;
      if (RD)
      begin
        if (ADDR == ADDR_CONTROL)
        begin
          RDATA <= ctrl_r;
        end
        else if (ADDR == ADDR_MODE)
        begin
          RDATA <= mode_r;
        end
        else if (ADDR == ADDR_STATUS)
        begin
          RDATA[ST_SETTLING]   <= (settle_r != 8'h00);
          RDATA[ST_RATE_ERR]   <= rate_err_r;
          RDATA[ST_NARROW_ERR] <= narrow_err_r;
        end
      end
    end
  end

endmodule : fsk_cfg_host

// ### sim/fsk_cfg_sva.sv
// link checks on configuration writes leaving the host controller
`timescale 1ns/1ns
module fsk_cfg_sva
  import fsk_cfg_pkg::*;
#(
  parameter int NARROW_SYM = NARROW_WAIT_SYMBOLS
)
(
  // clock and reset
  input wire logic       CLOCK,
  input wire logic       RSTN,
  // link
  input wire logic       wr_stb,
  input wire logic       reg_sel,
  input wire logic [7:0] wr_data
);
  // host may count a partial first symbol, so one symbol of slack
  localparam int NARROW_MIN = (NARROW_SYM - 1) * 2048;
  logic       ctl_wr;
  logic       mode_wr;
  logic [1:0] bw_r;
  int         med_r;

  assign ctl_wr  = wr_stb && reg_sel == SEL_CONTROL;
  assign mode_wr = wr_stb && reg_sel == SEL_MODE;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
      bw_r <= HOST_CONTROL_RST[1:0];
    else if (ctl_wr)
      bw_r <= wr_data[1:0];
  end

  // cycles spent at medium bandwidth, saturating
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN || (ctl_wr && wr_data[1:0] != BW_MEDIUM))
      med_r <= 0;
    else if (bw_r == BW_MEDIUM && med_r < NARROW_MIN)
      med_r <= med_r + 1;
  end

  a_rate_legal:
    assert property (ctl_wr |-> wr_data[7:6] inside {2'b10, 2'b11})
    else $error("control write with divider outside the legal rate");
  a_mode_low_zero:
    assert property (mode_wr |-> wr_data[2:0] == 3'h0)
    else $error("mode write with low bits set");
  a_narrow_entry:
    assert property (ctl_wr && wr_data[1:0] == BW_NARROW |-> bw_r inside {BW_NARROW, BW_MEDIUM})
    else $error("narrow loop entered from other than medium");
  a_narrow_wait:
    assert property (ctl_wr && wr_data[1:0] == BW_NARROW && bw_r != BW_NARROW
                     |-> med_r >= NARROW_MIN)
    else $error("narrow loop entered too early");
  a_reset_idle:
    assert property ($rose(RSTN) |-> !wr_stb && wr_data == 8'h00)
    else $error("link not idle after reset");
  // data and select only move together with a strobe
  a_link_hold:
    assert property (!wr_stb |-> $stable(wr_data) && $stable(reg_sel))
    else $error("link data changed without a strobe");

  c_mode_tx: cover property (mode_wr && wr_data[TX_BIT]);
  c_narrow: cover property (ctl_wr && wr_data[1:0] == BW_NARROW);
  c_div_top: cover property (ctl_wr && wr_data[7:6] == 2'b11);
endmodule : fsk_cfg_sva

// ### sim/test_fsk_modem_config_registers.sv
// self-checking bench: host controller and modem bank joined by the link
`timescale 1ns/1ns
`define CHK(n, e, g) check(n, 16'(e), 16'(g))
module test_fsk_modem_config_registers
  import fsk_cfg_pkg::*;
;
  logic       clock, rstn, ce, status_irq, level_acq, clock_acq, sync_start, sym_valid;
  logic       sync_last, host_wr, host_rd, symbol_tick, tx_mode, invert_tx, invert_rx;
  logic       cap_float, loop_open, eye_route, power_down, task_cancel, buffer_free_flag_set;
  logic       sync_found, irq_n_out, irq_n_oe;
  logic [1:0] rx_sym, exp_sym, addr, bw, level_mode, loop_bw;
  logic [7:0] wdata, rdata, m, prev;
  int         num_errors, samples_checked, cycles, found_n, cancel_n, buffer_free_flag_n, p, ec, eb;
  int         seed = 85;
  // model of sync outcomes, one entry per search
  int         found_q[$];
  logic [7:0] modes[8] = '{8'h20, 8'h20, 8'h60, 8'h28, 8'h20, 8'h00, 8'h90, 8'h08};
  logic [1:0] bws[4] = '{2'b11, 2'b00, 2'b10, 2'b01};

  fsk_cfg_if fsk_cfg_if_i();
  fsk_cfg_device fsk_cfg_device_i(.CLOCK(clock), .RSTN(rstn), .CE(ce),
    .LINK(fsk_cfg_if_i.dev), .STATUS_IRQ(status_irq), .LEVEL_ACQ(level_acq),
    .CLOCK_ACQ(clock_acq), .SYNC_START(sync_start), .SYM_VALID(sym_valid), .RX_SYM(rx_sym),
    .EXP_SYM(exp_sym), .SYNC_LAST(sync_last), .SYMBOL_TICK(symbol_tick), .TX_MODE(tx_mode),
    .INVERT_TX(invert_tx), .INVERT_RX(invert_rx), .LEVEL_MODE(level_mode),
    .CAP_FLOAT(cap_float), .LOOP_BW(loop_bw), .LOOP_OPEN(loop_open), .EYE_ROUTE(eye_route),
    .POWER_DOWN(power_down), .TASK_CANCEL(task_cancel), .BUFFER_FREE_FLAG_SET(buffer_free_flag_set),
    .SYNC_FOUND(sync_found), .IRQ_N_OUT(irq_n_out), .IRQ_N_OE(irq_n_oe));
  fsk_cfg_host #(.SETTLE_SYM(2), .NARROW_SYM(2)) fsk_cfg_host_i(.CLOCK(clock), .RSTN(rstn),
    .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(host_wr), .RD(host_rd), .RDATA(rdata),
    .LINK(fsk_cfg_if_i.host));
  fsk_cfg_sva #(.NARROW_SYM(2)) fsk_cfg_sva_i(.CLOCK(clock), .RSTN(rstn),
    .wr_stb(fsk_cfg_if_i.wr_stb), .reg_sel(fsk_cfg_if_i.reg_sel),
    .wr_data(fsk_cfg_if_i.wr_data));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // pulse counters, so a stuck pulse shows as an extra count
  always @(posedge clock)
  begin
    cycles++;
    found_n += (sync_found === 1'b1);
    cancel_n += (task_cancel === 1'b1);
    buffer_free_flag_n += (buffer_free_flag_set === 1'b1);
    if (cycles == 60000)
    begin
      num_errors++;
      $display("ERROR timeout expected done seen hung");
      tally_and_finish;
    end
  end

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic put(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    host_wr <= 1'b1;
    @(posedge clock);
    host_wr <= 1'b0;
    cyc(4);
  endtask : put

  task automatic expect_rd(input logic [1:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    addr <= a;
    host_rd <= 1'b1;
    @(posedge clock);
    host_rd <= 1'b0;
    #1;
    `CHK(n, e, rdata);
  endtask : expect_rd

  task automatic period(output int n);
    n = 0;
    while (symbol_tick !== 1'b1 && n < 9000)
    begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
    n = 1;
    while (symbol_tick !== 1'b1 && n < 9000)
    begin
      @(posedge clock);
      n++;
    end
  endtask : period

  task automatic sync_run(input int tol);
    int         s;
    int         x;
    logic [1:0] e;
    logic [1:0] r;
    s = 0;
    @(posedge clock);
    sync_start <= 1'b1;
    @(posedge clock);
    sync_start <= 1'b0;
    for (int k = 0; k < 24; k++)
    begin
      e = 2'($random(seed));
      r = (($random(seed) & 7) == 0) ? 2'($random(seed)) : e;
      s += (r > e) ? r - e : e - r;
      sym_valid <= 1'b1;
      rx_sym <= r;
      exp_sym <= e;
      sync_last <= (k == 23);
      @(posedge clock);
    end
    sym_valid <= 1'b0;
    sync_last <= 1'b0;
    x = found_n;
    cyc(3);
    found_q.push_back(int'(s <= 2 * tol));
    `CHK("sync_found", found_q[$], found_n - x);
  endtask : sync_run

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    {rstn, ce, status_irq, level_acq, clock_acq, sync_start, sym_valid, sync_last} = 8'h40;
    {rx_sym, exp_sym, addr, wdata, host_wr, host_rd} = '0;
    cyc(3);
    rstn <= 1'b1;
    `CHK("reset_outputs", 6'h00, {tx_mode, level_mode, loop_bw, power_down});
    expect_rd(ADDR_CONTROL, 8'hA6, "control_shadow");
    expect_rd(ADDR_MODE, 8'h00, "mode_shadow");
    put(2'h3, 8'h5A);
    expect_rd(2'h3, 8'h00, "unmapped");
    period(p);
    `CHK("period", 512, p);
    for (int c = 0; c < 4; c++)
    begin
      put(ADDR_CONTROL, {2'(c), 6'h26});
      expect_rd(ADDR_STATUS, (c < 2) ? 8'h02 : 8'h00, "rate_refused");
      period(p);
      period(p);
      `CHK("period", (c < 2) ? 512 : 512 << c, p);
    end
    put(ADDR_CONTROL, 8'hA7);
    put(ADDR_CONTROL, 8'hA5);
    expect_rd(ADDR_STATUS, 8'h04, "narrow_refused");
    foreach (bws[i])
    begin
      bw = bws[i];
      // narrow is only taken after the medium dwell
      if (bw == 2'b01)
        cyc(3 * 2048);
      put(ADDR_CONTROL, {4'hA, 2'(i), bw});
      `CHK("level_mode", i, level_mode);
      `CHK("cap_float", i == 0, cap_float);
      `CHK("loop_bw", bw, loop_bw);
      `CHK("loop_open", bw == 2'b00, loop_open);
      level_acq <= 1'b1;
      clock_acq <= 1'b1;
      cyc(3);
      `CHK("acq_override", 4'hF, {level_mode, loop_bw});
      level_acq <= 1'b0;
      clock_acq <= 1'b0;
    end
    for (int t = 0; t < 8; t++)
    begin
      put(ADDR_CONTROL, {2'b10, 2'(t / 2), 4'h6});
      level_acq <= 1'b1;
      sync_run(t / 2);
      // slow peak only until sync is seen, then level track again
      `CHK("acq_release", (found_q[$] != 0) ? 2'b01 : 2'b11, level_mode);
      level_acq <= 1'b0;
    end
    status_irq <= 1'b1;
    prev = 8'h00;
    foreach (modes[i])
    begin
      m = modes[i];
      ec = cancel_n;
      eb = buffer_free_flag_n;
      put(ADDR_MODE, m | 8'($random(seed) & 7));
      `CHK("tx_mode", m[TX_BIT], tx_mode);
      `CHK("invert", {m[INV_BIT], !m[INV_BIT]}, {invert_tx, invert_rx});
      `CHK("eye", m[EYE_BIT] & !m[TX_BIT] & !m[POWER_SAVE_BIT], eye_route);
      `CHK("power_down", m[POWER_SAVE_BIT], power_down);
      `CHK("cancel", ec + (m[TX_BIT] ^ prev[TX_BIT]), cancel_n);
      `CHK("buffer_free_flag", eb + ((m[5] ^ prev[5]) | (m[3] ^ prev[3])), buffer_free_flag_n);
      `CHK("irq_pin", {m[IRQ_EN_BIT], 1'b0}, {irq_n_oe, irq_n_out});
      if (m[TX_BIT])
        `CHK("tx_parked", 4'h0, {level_mode, loop_bw});
      expect_rd(ADDR_MODE, m, "mode_shadow");
      prev = m;
    end
    put(ADDR_MODE, 8'h00);
    expect_rd(ADDR_STATUS, 8'h01, "settling");
    status_irq <= 1'b0;
    put(ADDR_MODE, 8'h80);
    `CHK("irq_quiet", 1'b0, irq_n_oe);
    status_irq <= 1'b1;
    cyc(2);
    `CHK("irq_raised", 1'b1, irq_n_oe);
    ce <= 1'b0;
    put(ADDR_MODE, 8'h20);
    ce <= 1'b1;
    cyc(2);
    `CHK("frozen", 1'b0, tx_mode);
    tally_and_finish;
  end
endmodule : test_fsk_modem_config_registers
